// ===== rtl/imdsc_pkg.sv
// package: register map, field positions, timing counts and carrier types
// assumes a 20 MHz ref_clk and a two-wire bus near 2.5 MHz
package imdsc_pkg;

  localparam int CLK_MHZ     = 20;
  localparam int SCL_HALF_NS = 200;
  localparam int HALF_CYC    = (SCL_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] HALF_CNT = 8'(HALF_CYC);

  localparam logic [7:0] IDX_MSHIFT = 8'h08;
  localparam logic [7:0] IDX_SENA   = 8'h09;
  localparam logic [7:0] IDX_SACK   = 8'h0A;
  localparam logic [9:0] ADR_MSHIFT = {IDX_MSHIFT, 2'b00};
  localparam logic [9:0] ADR_SENA   = {IDX_SENA, 2'b00};
  localparam logic [9:0] ADR_SACK   = {IDX_SACK, 2'b00};

  localparam logic [7:0] MSHIFT_RST = 8'h00;
  localparam logic [7:0] SENA_RST   = 8'h00;
  localparam logic       ACKSEL_RST = 1'b0;
  localparam logic [7:0] SENA_MSK   = 8'hE7;

  localparam int A_DATA_IE = 7;
  localparam int A_ADST_IE = 6;
  localparam int A_STOP_EN = 5;
  localparam int A_ALL_ADR = 2;
  localparam int A_SMART   = 1;
  localparam int A_EN      = 0;
  localparam int B_ACK     = 2;

  localparam logic [1:0] CMD_NONE  = 2'h0;
  localparam logic [1:0] CMD_COMP  = 2'h2;
  localparam logic [1:0] CMD_RESP  = 2'h3;
  localparam logic [3:0] LAST_SLOT = 4'h8;
  localparam logic       CAUSE_STOP = 1'b0;
  localparam logic       CAUSE_ADDR = 1'b1;

  typedef struct packed {
    logic scl;
    logic sda;
  } imdsc_pins_type;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } imdsc_drive_type;

  typedef struct packed {
    logic       wr_done;
    logic       rd_done;
    logic       arb;
    logic       berr;
    logic       hold;
  } imdsc_mflags_type;

endpackage

// ===== rtl/imdsc_core.sv
// file: master byte shift engine and slave control/command registers
// assumes word register port on ref_clk; bus pins are asynchronous
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps

// What this block does
// - data register is the master shift register
// - data writes ignored while a byte shifts
// - write sends byte, clocks ack slot without keeping it, sets write flag
// - after arbitration loss send ones, finish byte
// - data write clears read/write/hold flags only
// - read sends ack bit, releases clock one byte
// - read done sets read flag, else write flag
// - data read with ack action clears both flags
// - data irq needs enable, flag, global enable
// - addr/stop irq needs enable, flag, global enable
// - address and stop share flag; cause bit kept
// - stop enable lets stop set the flag
// - accept-all mode takes every address
// - smart mode: access clears flag, continues transfer
// - enable bit turns slave function on/off
// - acknowledge action is plain read/write bit
// - command bits are strobes, read as zero
// - command 2 completes, command 3 responds
// - cause bit: 0 stop, 1 address
module imdsc_core
  import imdsc_pkg::*;
(
  input  wire logic            ref_clk,             // system clock
  input  wire logic            rst,                 // async reset, high
  input  wire logic [9:0]      addr,                // byte address
  input  wire logic [7:0]      wdata,               // write data
  input  wire logic            wr,                  // write strobe
  input  wire logic            rd,                  // read strobe
  output logic      [7:0]      rdata,               // read data, cycle after rd
  input  wire imdsc_pins_type  pin_in,              // scl/sda wire levels
  output imdsc_drive_type      pin_drv,             // scl/sda drive and enables
  input  wire logic            m_ack_valid,         // master ack action is ack or nack
  input  wire logic            m_ack_nack,          // master ack action: 1 nack
  input  wire logic            m_bus_error,         // bus error pulse
  input  wire logic            m_flags_clear,       // clear all master flags pulse
  output imdsc_mflags_type     m_flags,             // master status flags
  input  wire logic            global_irq_enable,   // cpu global enable
  input  wire logic [6:0]      slave_own_address,   // programmed slave address
  input  wire logic            s_addr_valid,        // address byte received pulse
  input  wire logic [7:0]      s_addr_byte,         // received address byte
  input  wire logic            s_byte_done,         // slave byte finished pulse
  input  wire logic            s_data_access,       // slave data read/write pulse
  output logic                 slave_data_flag,     // data flag
  output logic                 slave_addr_stop_flag,// address-or-stop flag
  output logic                 addr_or_stop_cause,  // 1 address, 0 stop
  output logic                 s_addr_match,        // address accepted pulse
  output logic                 s_enable,            // slave function on
  output logic                 s_ack_action,        // 1 send nack
  output logic                 s_cmd_complete,      // command 2 pulse
  output logic                 s_cmd_response,      // command 3 pulse
  output logic                 s_smart_continue,    // smart-mode continue pulse
  output logic                 slave_data_irq,      // data interrupt request
  output logic                 slave_addr_stop_irq  // addr/stop interrupt request
);

  typedef enum logic [1:0] {M_IDLE, M_LOW, M_HIGH_WAIT, M_HIGH} imdsc_mst_type;

  typedef struct packed {
    // master byte engine
    imdsc_mst_type    mst;
    logic [7:0]       cnt;
    logic [3:0]       slot;
    logic             rx;
    logic             op_arb;
    logic             op_berr;
    logic             nack;
    logic [7:0]       shreg;
    imdsc_drive_type  drv;
    imdsc_mflags_type mf;

    // slave control copies and flags
    logic [7:0]       ctla;
    logic             ack_act;
    logic             dflag;
    logic             apflag;
    logic             cause;
    logic             match;

    // one-cycle strobes and interrupt requests
    logic             cmd_comp;
    logic             cmd_resp;
    logic             smart_go;
    logic             dirq;
    logic             apirq;

    // read port and pin synchronisers
    logic [7:0]       rdata;
    logic [1:0]       scl_s;
    logic [1:0]       sda_s;
    logic             scl_p;
    logic             sda_p;
  } imdsc_state_type;

  imdsc_state_type st_q;
  imdsc_state_type st_d;

  localparam imdsc_state_type ST_RST = '{
    mst:     M_IDLE,
    cnt:     8'h00,
    slot:    4'h0,
    rx:      1'b0,
    op_arb:  1'b0,
    op_berr: 1'b0,
    nack:    1'b0,
    shreg:   MSHIFT_RST,
    drv:     '0,
    mf:      '0,
    ctla:    SENA_RST,
    ack_act: ACKSEL_RST,
    dflag:   1'b0,
    apflag:  1'b0,
    cause:   1'b0,
    match:   1'b0,
    cmd_comp:1'b0,
    cmd_resp:1'b0,
    smart_go:1'b0,
    dirq:    1'b0,
    apirq:   1'b0,
    rdata:   8'h00,
    scl_s:   2'b11,
    sda_s:   2'b11,
    scl_p:   1'b1,
    sda_p:   1'b1
  };

  always_comb begin
    logic scl_v;
    logic sda_v;
    logic wr_md;
    logic rd_md;
    logic wr_b;
    logic drove_one;
    logic data_slot;
    logic stop_ev;
    logic addr_ok;
    logic s_clear;
    logic ack_slot;
    scl_v     = 1'b0;
    sda_v     = 1'b0;
    wr_md     = 1'b0;
    rd_md     = 1'b0;
    wr_b      = 1'b0;
    drove_one = 1'b0;
    data_slot = 1'b0;
    stop_ev   = 1'b0;
    addr_ok   = 1'b0;
    s_clear   = 1'b0;
    ack_slot  = 1'b0;
    st_d      = st_q;

    // two-flop synchronisers, edges taken from the second stage
    st_d.scl_s = {st_q.scl_s[0], pin_in.scl};
    st_d.sda_s = {st_q.sda_s[0], pin_in.sda};
    scl_v      = st_q.scl_s[1];
    sda_v      = st_q.sda_s[1];
    st_d.scl_p = scl_v;
    st_d.sda_p = sda_v;

    // decoded register strobes
    wr_md = wr && (addr == ADR_MSHIFT);
    rd_md = rd && (addr == ADR_MSHIFT);
    wr_b  = wr && (addr == ADR_SACK);

    // register read port
    // read data stands one cycle, zero otherwise
    st_d.rdata = 8'h00;
    if (rd) begin
      case (addr)
        ADR_MSHIFT: st_d.rdata = st_q.shreg;
        ADR_SENA:   st_d.rdata = st_q.ctla & SENA_MSK;
        ADR_SACK:   st_d.rdata = {5'h00, st_q.ack_act, 2'b00};
        default:    st_d.rdata = 8'h00;
      endcase
    end

    // bits 4 and 3 of the enable register are never stored
    if (wr && (addr == ADR_SENA)) begin
      st_d.ctla = wdata & SENA_MSK;
    end

    // command bits are not stored, only decoded below
    if (wr_b) begin
      st_d.ack_act = wdata[B_ACK];
    end

    // master flags: software-side clears first, hardware sets win below
    if (m_flags_clear) begin
      st_d.mf = '0;
    end
    if (st_q.mst != M_IDLE && m_bus_error) begin
      st_d.op_berr = 1'b1;
    end

    // master byte engine
    case (st_q.mst)
      M_IDLE: begin
        // writes while busy fall through and are lost
        if (wr_md) begin
          st_d.shreg   = wdata;
          st_d.mf.wr_done = 1'b0;
          st_d.mf.rd_done = 1'b0;
          st_d.mf.hold = 1'b0;
          st_d.rx      = 1'b0;
          st_d.slot    = 4'h0;
          st_d.cnt     = 8'h00;
          st_d.op_arb  = 1'b0;
          st_d.op_berr = 1'b0;
          st_d.drv.scl_oe = 1'b1;
          st_d.mst     = M_LOW;
        end else if (rd_md && m_ack_valid) begin
          // a read without an acknowledge action only returns data
          st_d.mf.wr_done = 1'b0;
          st_d.mf.rd_done = 1'b0;
          st_d.mf.hold = 1'b0;
          st_d.rx      = 1'b1;
          st_d.nack    = m_ack_nack;
          st_d.slot    = 4'h0;
          st_d.cnt     = 8'h00;
          st_d.op_arb  = 1'b0;
          st_d.op_berr = 1'b0;
          st_d.drv.scl_oe = 1'b1;
          st_d.mst     = M_LOW;
        end
      end
      M_LOW: begin
        st_d.cnt = st_q.cnt + 8'h01;
        if (st_q.cnt == 8'h01) begin
          // change sda well after scl has fallen
          if (st_q.rx) begin
            ack_slot = (st_q.slot == 4'h0);
            st_d.drv.sda_oe = ack_slot && !st_q.nack;
          end else if (st_q.slot != LAST_SLOT) begin
            st_d.drv.sda_oe = !st_q.shreg[7] && !st_q.op_arb;
          end else begin
            st_d.drv.sda_oe = 1'b0;
          end
        end
        if (st_q.cnt == HALF_CNT) begin
          st_d.drv.scl_oe = 1'b0;
          st_d.cnt        = 8'h00;
          st_d.mst        = M_HIGH_WAIT;
        end
      end
      M_HIGH_WAIT: begin
        // a slave may stretch the clock
        if (scl_v) begin
          st_d.cnt = 8'h00;
          st_d.mst = M_HIGH;
        end
      end
      M_HIGH: begin
        st_d.cnt = st_q.cnt + 8'h01;
        if (st_q.cnt == HALF_CNT - 8'h01) begin
          drove_one = st_q.rx ? (st_q.slot == 4'h0) : (st_q.slot != LAST_SLOT);
          data_slot = st_q.rx ? (st_q.slot != 4'h0) : (st_q.slot != LAST_SLOT);
          if (drove_one && !st_q.drv.sda_oe && !sda_v) begin
            st_d.op_arb = 1'b1;
            st_d.mf.arb = 1'b1;
          end
          if (data_slot) begin
            st_d.shreg = {st_q.shreg[6:0], sda_v};
          end
          st_d.cnt        = 8'h00;
          st_d.drv.scl_oe = 1'b1;
          if (st_q.slot == LAST_SLOT) begin
            st_d.mst        = M_IDLE;
            st_d.mf.hold    = 1'b1;
            st_d.drv.sda_oe = 1'b0;
            // the two master flags are never raised together
            if (!st_q.rx) begin
              st_d.mf.wr_done = 1'b1;
            end else if (st_q.op_berr || m_bus_error ||
                         (st_q.nack && (st_q.op_arb || st_d.op_arb))) begin
              st_d.mf.wr_done = 1'b1;
            end else begin
              st_d.mf.rd_done = 1'b1;
            end
          end else begin
            st_d.slot = st_q.slot + 4'h1;
            st_d.mst  = M_LOW;
          end
        end
      end
      default: begin
        st_d.mst = M_IDLE;
      end
    endcase
    if (m_bus_error) begin
      st_d.mf.berr = 1'b1;
    end

    // slave command strobes and smart-mode continuation
    // codes 0 and 1 launch nothing
    st_d.cmd_comp = wr_b && (wdata[1:0] == CMD_COMP);
    st_d.cmd_resp = wr_b && (wdata[1:0] == CMD_RESP);

    // smart mode lets a data access stand in for a command
    st_d.smart_go = s_data_access && st_q.ctla[A_SMART];
    s_clear = st_d.cmd_comp || st_d.cmd_resp || st_d.smart_go;
    if (s_clear) begin
      st_d.dflag  = 1'b0;
      st_d.apflag = 1'b0;
    end

    // slave events set flags after any clear, so a set is never lost
    // stop: sda rises while scl stays high, both on synced levels
    stop_ev = scl_v && st_q.scl_p && sda_v && !st_q.sda_p;
    // accept-all mode ignores the programmed address
    addr_ok = s_addr_valid &&
              (st_q.ctla[A_ALL_ADR] || (s_addr_byte[7:1] == slave_own_address));
    st_d.match = addr_ok && st_q.ctla[A_EN];
    if (st_q.ctla[A_EN]) begin
      if (s_byte_done) begin
        st_d.dflag = 1'b1;
      end
      if (stop_ev && st_q.ctla[A_STOP_EN]) begin
        st_d.apflag = 1'b1;
        st_d.cause  = CAUSE_STOP;
      end
      // an address in the same cycle as a stop wins the cause bit
      if (addr_ok) begin
        st_d.apflag = 1'b1;
        st_d.cause  = CAUSE_ADDR;
      end
    end

    // requests follow the next flag value, so they rise with the flag
    st_d.dirq  = st_d.dflag && st_d.ctla[A_DATA_IE] && global_irq_enable;
    st_d.apirq = st_d.apflag && st_d.ctla[A_ADST_IE] && global_irq_enable;
    st_d.drv.scl_o = 1'b0;
    st_d.drv.sda_o = 1'b0;
  end

  // single state register; its reset value is a constant, so the
  // asynchronous branch never depends on other logic
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // every output is a field of the state register
  assign rdata                = st_q.rdata;
  assign pin_drv              = st_q.drv;
  assign m_flags              = st_q.mf;
  assign slave_data_flag      = st_q.dflag;
  assign slave_addr_stop_flag = st_q.apflag;
  assign addr_or_stop_cause   = st_q.cause;
  assign s_addr_match         = st_q.match;
  assign s_enable             = st_q.ctla[A_EN];
  assign s_ack_action         = st_q.ack_act;
  assign s_cmd_complete       = st_q.cmd_comp;
  assign s_cmd_response       = st_q.cmd_resp;
  assign s_smart_continue     = st_q.smart_go;
  assign slave_data_irq       = st_q.dirq;
  assign slave_addr_stop_irq  = st_q.apirq;

endmodule

// ===== testbench/imdsc_core_assertions.sv
// checker: register port, master flag and slave event relations
// assumes binding onto imdsc_core and sight of its ports only
`timescale 1ns/1ps
module imdsc_core_assertions
  import imdsc_pkg::*;
(
  input wire logic             ref_clk,              // clock
  input wire logic             rst,                  // reset
  input wire logic [9:0]       addr,                 // address
  input wire logic [7:0]       wdata,                // write data
  input wire logic             wr,                   // write
  input wire logic             rd,                   // read
  input wire logic [7:0]       rdata,                // read data
  input wire logic             m_ack_valid,          // ack action set
  input wire logic             m_bus_error,          // bus error
  input wire logic             m_flags_clear,        // flag clear
  input wire imdsc_mflags_type m_flags,              // master flags
  input wire imdsc_drive_type  pin_drv,              // pin drive
  input wire logic             global_irq_enable,    // global enable
  input wire logic [6:0]       slave_own_address,    // own address
  input wire logic             s_addr_valid,         // address event
  input wire logic [7:0]       s_addr_byte,          // address byte
  input wire logic             s_enable,             // slave on
  input wire logic             s_ack_action,         // ack action
  input wire logic             s_cmd_complete,       // command 2
  input wire logic             s_cmd_response,       // command 3
  input wire logic             slave_data_flag,      // data flag
  input wire logic             slave_addr_stop_flag, // addr/stop flag
  input wire logic             addr_or_stop_cause,   // cause
  input wire logic             s_addr_match,         // match
  input wire logic             slave_data_irq,       // data irq
  input wire logic             slave_addr_stop_irq   // addr/stop irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic m_wr;
  logic m_rd;
  logic fl;
  assign m_wr = wr && addr == ADR_MSHIFT && !m_bus_error && !m_flags_clear;
  assign m_rd = rd && addr == ADR_MSHIFT && m_ack_valid && !m_bus_error && !m_flags_clear;
  assign fl = m_flags.wr_done || m_flags.rd_done;
  a_flags_exclusive: assert property (!(m_flags.wr_done && m_flags.rd_done))
    else $error("read and write flags both set");
  a_hold_pulls_scl: assert property (m_flags.hold |-> pin_drv.scl_oe)
    else $error("clock hold without scl low");
  a_write_clears: assert property (m_wr && fl |=> !fl && $stable({m_flags.arb, m_flags.berr}))
    else $error("data write flag side effect wrong");
  a_read_clears: assert property (m_rd && fl |=> !fl && $stable({m_flags.arb, m_flags.berr}))
    else $error("data read flag side effect wrong");
  a_addr_accept: assert property (s_addr_valid && s_enable && s_addr_byte[7:1] == slave_own_address
    |=> s_addr_match && slave_addr_stop_flag && addr_or_stop_cause)
    else $error("own address not accepted");
  a_slave_off: assert property (s_addr_valid && !s_enable |=> !s_addr_match)
    else $error("disabled slave matched");
  a_irq_gated: assert property ((!global_irq_enable) [*2] |-> !slave_data_irq && !slave_addr_stop_irq)
    else $error("irq without global enable");
  a_acknowledge_action_write: assert property ($changed(s_ack_action) |-> $past(wr) && $past(addr) == ADR_SACK
    && s_ack_action == $past(wdata[B_ACK]))
    else $error("ack action changed without write");
  a_cmd_complete: assert property (wr && addr == ADR_SACK && wdata[1:0] == CMD_COMP
    |=> s_cmd_complete && !s_cmd_response)
    else $error("command 2 pulse missing");
  a_cmd_respond: assert property (wr && addr == ADR_SACK && wdata[1:0] == CMD_RESP
    |=> s_cmd_response && !s_cmd_complete)
    else $error("command 3 pulse missing");
  a_ctrlb_read: assert property (rd && addr == ADR_SACK |=> rdata == {5'h00, s_ack_action, 2'h0})
    else $error("ctrl b read value wrong");
  a_ctrla_read: assert property (rd && addr == ADR_SENA |=> (rdata & ~SENA_MSK) == 8'h00)
    else $error("ctrl a unused bits set");
  c_tx_done: cover property (m_flags.wr_done && m_flags.arb);
  c_rx_done: cover property (m_flags.rd_done);
  c_stop: cover property (slave_addr_stop_flag && !addr_or_stop_cause);
endmodule

bind imdsc_core imdsc_core_assertions u_imdsc_core_assertions (.*);

// ===== testbench/imdsc_bus_partner.sv
// partner: bus target that acks, sends a byte or fights for the bus
// assumes open-drain wires with pull-ups and scl made by the master
`timescale 1ns/1ps
module imdsc_bus_partner (
  input  wire logic       scl,     // wire level
  input  wire logic       sda,     // wire level
  input  wire logic       arm,     // restart slot count
  input  wire logic       rx,      // send tx_byte after ack slot
  input  wire logic       ack,     // ack a written byte
  input  wire logic       fight,   // pull data slots low
  input  wire logic [7:0] tx_byte, // byte to send
  output logic            pull,    // pulls sda low
  output logic      [7:0] got      // byte taken from master
);
  int cnt;
  initial pull = 1'b0;
  always @(posedge scl or posedge arm) begin
    if (arm) begin
      cnt <= 0;
    end else begin
      if (cnt < 8) got <= {got[6:0], sda};
      cnt <= cnt + 1;
    end
  end
  // change data well after scl falls, never while it is high
  always @(negedge scl or posedge arm) begin
    if (arm) pull <= 1'b0;
    else if (rx) pull <= #150 (cnt inside {[1:8]}) && !tx_byte[8 - cnt];
    else pull <= #150 (cnt == 8 && ack) || (cnt < 8 && fight);
  end
endmodule

// ===== testbench/imdsc_core_tb_top.sv
// testbench: register tasks, master byte transfers, slave event sequences
// assumes imdsc_core, the bus partner model and the bound checker
`timescale 1ns/1ps
module imdsc_core_tb_top import imdsc_pkg::*;;
  logic             ref_clk, rst, wr, rd, m_ack_valid, m_ack_nack, global_irq_enable;
  logic             s_addr_valid, s_byte_done, s_data_access, m_bus_error, m_flags_clear;
  logic             arm, rx, ack, fight, pull, tb_pull, s_enable, s_ack_action, s_cmd_complete;
  logic             s_cmd_response, s_smart_continue, s_addr_match, slave_data_flag;
  logic             slave_addr_stop_flag, addr_or_stop_cause, slave_data_irq, slave_addr_stop_irq;
  logic [4:0]       ev;
  logic [9:0]       addr;
  logic [7:0]       wdata, rdata, s_addr_byte, tx_byte, got, v;
  logic [6:0]       slave_own_address;
  logic [9:0]       map [4] = '{ADR_MSHIFT, ADR_SENA, ADR_SACK, 10'h02C};
  imdsc_pins_type   pin_in;
  imdsc_drive_type  pin_drv;
  imdsc_mflags_type m_flags;
  int               errors, check_count;

  assign {s_addr_valid, s_byte_done, s_data_access, m_bus_error, m_flags_clear} = ev;
  assign pin_in = {!pin_drv.scl_oe, !(pin_drv.sda_oe || pull || tb_pull)};

  imdsc_core u_imdsc_core (.*);
  imdsc_bus_partner u_imdsc_bus_partner (.scl(pin_in.scl), .sda(pin_in.sda), .arm(arm), .rx(rx),
    .ack(ack), .fight(fight), .tx_byte(tx_byte), .pull(pull), .got(got));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wreg(input logic [9:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [9:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic pulse(input logic [4:0] p);
    @(posedge ref_clk);
    ev <= p;
    @(posedge ref_clk);
    ev <= 5'h00;
    #1;
  endtask
  task automatic rearm();
    arm = 1'b1;
    #1 arm = 1'b0;
  endtask
  task automatic wait_flag();
    int n;
    n = 0;
    while (!(m_flags.wr_done || m_flags.rd_done) && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 400) begin
      errors++;
      $display("BAD %0t no master flag", $time);
      final_report();
    end
    tick(1);
  endtask

  initial begin
    rst = 1'b1;
    {addr, wdata, wr, rd, ev, m_ack_valid, m_ack_nack, global_irq_enable} = '0;
    {s_addr_byte, arm, rx, ack, fight, tb_pull, tx_byte} = '0;
    slave_own_address = 7'h2A;
    errors = 0;
    check_count = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (map[i]) begin
      rreg(map[i]);
      chk(v, 8'h00);
    end
    wreg(ADR_SENA, 8'hFF);
    rreg(ADR_SENA);
    chk(v, 8'hE7);
    chk({7'h00, s_enable}, 8'h01);
    wreg(ADR_SACK, 8'hFF);
    rreg(ADR_SACK);
    chk(v, 8'h04);
    chk({7'h00, s_ack_action}, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wreg(ADR_SACK, 8'(c));
      chk({6'h00, s_cmd_complete, s_cmd_response}, c == 2 ? 8'h02 : c == 3 ? 8'h01 : 8'h00);
    end
    // start then stop on an idle bus
    global_irq_enable <= 1'b1;
    tb_pull <= 1'b1;
    tick(4);
    tb_pull <= 1'b0;
    tick(6);
    chk({5'h00, slave_addr_stop_irq, slave_addr_stop_flag, addr_or_stop_cause}, 8'h06);
    wreg(ADR_SACK, 8'h02);
    chk({7'h00, slave_addr_stop_flag}, 8'h00);
    s_addr_byte <= 8'h90;
    pulse(5'h10);
    chk({4'h0, slave_addr_stop_irq, s_addr_match, slave_addr_stop_flag, addr_or_stop_cause}, 8'h0F);
    global_irq_enable <= 1'b0;
    tick(2);
    chk({7'h00, slave_addr_stop_irq}, 8'h00);
    global_irq_enable <= 1'b1;
    wreg(ADR_SACK, 8'h03);
    chk({7'h00, slave_addr_stop_flag}, 8'h00);
    wreg(ADR_SENA, 8'hE3);
    pulse(5'h10);
    chk({7'h00, s_addr_match}, 8'h00);
    s_addr_byte <= 8'h54;
    pulse(5'h10);
    chk({7'h00, s_addr_match}, 8'h01);
    pulse(5'h08);
    chk({6'h00, slave_data_flag, slave_data_irq}, 8'h03);
    pulse(5'h04);
    chk({6'h00, slave_data_flag, s_smart_continue}, 8'h01);
    wreg(ADR_SENA, 8'h21);
    pulse(5'h08);
    pulse(5'h04);
    chk({6'h00, slave_data_flag, slave_data_irq}, 8'h02);
    wreg(ADR_SENA, 8'h00);
    pulse(5'h10);
    chk({7'h00, s_addr_match}, 8'h00);
    ack <= 1'b1;
    rearm();
    wreg(ADR_MSHIFT, 8'hA5);
    wreg(ADR_MSHIFT, 8'h3C);
    wait_flag();
    chk(got, 8'hA5);
    chk({5'h00, m_flags.wr_done, m_flags.rd_done, m_flags.arb}, 8'h04);
    rx <= 1'b1;
    tx_byte <= 8'hC3;
    m_ack_valid <= 1'b1;
    rearm();
    rreg(ADR_MSHIFT);
    chk({6'h00, m_flags.wr_done, m_flags.rd_done}, 8'h00);
    wait_flag();
    chk({6'h00, m_flags.wr_done, m_flags.rd_done}, 8'h01);
    m_ack_valid <= 1'b0;
    rreg(ADR_MSHIFT);
    chk(v, 8'hC3);
    pulse(5'h02);
    rx <= 1'b0;
    fight <= 1'b1;
    rearm();
    wreg(ADR_MSHIFT, 8'hFF);
    wait_flag();
    chk({5'h00, m_flags.wr_done, m_flags.arb, m_flags.berr}, 8'h07);
    fight <= 1'b0;
    rearm();
    wreg(ADR_MSHIFT, 8'h5A);
    chk({5'h00, m_flags.wr_done, m_flags.arb, m_flags.berr}, 8'h03);
    wait_flag();
    chk(got, 8'h5A);
    pulse(5'h01);
    chk({3'h0, m_flags}, 8'h00);
    final_report();
  end
endmodule
